/* dv/spims_far_slave.sv */
// Purpose: Far-side serial slave for master-mode transfers
// Assumes: Clock idles low, data latched on the leading edge
// Notes:   Replies 96h then 5Ah; inverted fill between loads
`timescale 1ns/1ps
module spims_far_slave (
   input  wire        sck,
   input  wire        mosi,
   output reg         miso,
   output reg  [15:0] rx_all,
   output integer     nbits
);
   reg [7:0] tx [0:1];
   reg [7:0] sh;
   initial begin
      tx[0] = 8'h96;
      tx[1] = 8'h5a;
      sh = tx[0];
      miso = sh[7];
      rx_all = 16'h0000;
      nbits = 0;
   end
   // Same phase and polarity as the port
   always @(posedge sck) begin
      rx_all = {rx_all[14:0], mosi};
      nbits = nbits + 1;
   end
   // Only slave on the wire, so it always drives
   always @(negedge sck) begin
      if (nbits % 8 == 0) begin
         if (nbits > 0) sh = tx[(nbits / 8) % 2];
      end else begin
         sh = {sh[6:0], ~sh[7]};
      end
      miso = sh[7];
   end
endmodule // spims_far_slave

/* dv/spims_properties.sv */
// Purpose: Port-level properties of the serial port top
// Assumes: One CLK domain, RST async active high
// Notes:   Bound to every spims_top instance
`timescale 1ns/1ps
module spims_properties (
   input wire        CLK,
   input wire        RST,
   input wire        S_AXI_AWVALID,
   input wire        S_AXI_AWREADY,
   input wire        S_AXI_WVALID,
   input wire        S_AXI_WREADY,
   input wire        S_AXI_BVALID,
   input wire        S_AXI_ARVALID,
   input wire        S_AXI_ARREADY,
   input wire        S_AXI_RVALID,
   input wire        SCK_OE,
   input wire        MOSI_OE,
   input wire        MISO_OE,
   input wire        NSS_I,
   input wire        NSS_OE,
   input wire        NSS_ROUTED
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   AST_MOSI_WITH_SCK: assert property (SCK_OE |-> MOSI_OE)
      else $error("MOSI not driven while master");
   AST_NO_MISO_MASTER: assert property (SCK_OE |-> !MISO_OE)
      else $error("MISO driven while master");
   AST_SEL_OUT_ROUTED: assert property (NSS_OE |-> NSS_ROUTED)
      else $error("select driven but not routed");
   AST_SEL_OUT_NO_MISO: assert property (NSS_OE |-> !MISO_OE)
      else $error("MISO driven in select output mode");
   // Sync stages and edge detect give a few cycles of slack
   AST_FAULT_STOPS: assert property (NSS_ROUTED && !NSS_OE && SCK_OE && $fell(NSS_I)
      |-> ##[1:8] !SCK_OE)
      else $error("master not stopped by select fall");
   AST_AW_REFUSED: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while response pending");
   AST_W_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
      else $error("write response late");
   AST_R_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read response late");
   AST_AR_REFUSED: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while data pending");
endmodule // spims_properties

bind spims_top spims_properties u_props (
   .CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .SCK_OE(SCK_OE), .MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE),
   .NSS_I(NSS_I), .NSS_OE(NSS_OE), .NSS_ROUTED(NSS_ROUTED));

/* dv/test_spims_top.sv */
// Purpose: Register-level tests of the serial port top
// Assumes: Phase and polarity left at zero throughout
// Notes:   Divider 3 gives an 800 ns serial clock
`timescale 1ns/1ps
module test_spims_top;
   reg         CLK = 1'b0;
   reg         RST = 1'b1;
   reg  [3:0]  S_AXI_AWADDR = 4'h0;
   reg         S_AXI_AWVALID = 1'b0;
   reg  [31:0] S_AXI_WDATA = 32'h0;
   reg  [3:0]  S_AXI_WSTRB = 4'hf;
   reg         S_AXI_WVALID = 1'b0;
   reg         S_AXI_BREADY = 1'b0;
   reg  [3:0]  S_AXI_ARADDR = 4'h0;
   reg         S_AXI_ARVALID = 1'b0;
   reg         S_AXI_RREADY = 1'b0;
   reg         NSS_I = 1'b1;
   wire        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   wire [31:0] S_AXI_RDATA, far_bits;
   wire        SCK_I, SCK_O, SCK_OE, MOSI_I, MOSI_O, MOSI_OE, MISO_I, MISO_O, MISO_OE;
   wire        NSS_O, NSS_OE, NSS_ROUTED, IRQ, miso_far;
   wire [15:0] far_rx;
   integer     num_errors = 0;
   integer     total_checks = 0;
   integer     cyc = 0;
   integer     i, j;
   reg  [31:0] rd;
   reg  [1:0]  rsp;
   localparam [31:0] SL_CTRL = 32'h05050104;
   localparam [3:0]  SL_NSS = 4'b1010;
   localparam [3:0]  SL_OE = 4'b0110;

   assign SCK_I  = SCK_OE ? SCK_O : 1'b0;
   assign MOSI_I = MOSI_OE ? MOSI_O : 1'b0;
   assign MISO_I = MISO_OE ? MISO_O : miso_far;

   spims_top u_dut (
      .CLK           (CLK),           .RST           (RST),
      .S_AXI_AWADDR  (S_AXI_AWADDR),  .S_AXI_AWVALID (S_AXI_AWVALID),
      .S_AXI_AWREADY (S_AXI_AWREADY), .S_AXI_WDATA   (S_AXI_WDATA),
      .S_AXI_WSTRB   (S_AXI_WSTRB),   .S_AXI_WVALID  (S_AXI_WVALID),
      .S_AXI_WREADY  (S_AXI_WREADY),  .S_AXI_BRESP   (S_AXI_BRESP),
      .S_AXI_BVALID  (S_AXI_BVALID),  .S_AXI_BREADY  (S_AXI_BREADY),
      .S_AXI_ARADDR  (S_AXI_ARADDR),  .S_AXI_ARVALID (S_AXI_ARVALID),
      .S_AXI_ARREADY (S_AXI_ARREADY), .S_AXI_RDATA   (S_AXI_RDATA),
      .S_AXI_RRESP   (S_AXI_RRESP),   .S_AXI_RVALID  (S_AXI_RVALID),
      .S_AXI_RREADY  (S_AXI_RREADY),  .SCK_I         (SCK_I),
      .SCK_O         (SCK_O),         .SCK_OE        (SCK_OE),
      .MOSI_I        (MOSI_I),        .MOSI_O        (MOSI_O),
      .MOSI_OE       (MOSI_OE),       .MISO_I        (MISO_I),
      .MISO_O        (MISO_O),        .MISO_OE       (MISO_OE),
      .NSS_I         (NSS_I),         .NSS_O         (NSS_O),
      .NSS_OE        (NSS_OE),        .NSS_ROUTED    (NSS_ROUTED),
      .IRQ           (IRQ)
   );
   spims_far_slave u_far (.sck(SCK_I), .mosi(MOSI_I), .miso(miso_far), .rx_all(far_rx),
      .nbits(far_bits));

   always #50 CLK = ~CLK;
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors = num_errors + 1;
         finish_test;
      end
   end

   task check(input [8*8:1] nm, input [31:0] exp, input [31:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask

   task axi_wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge CLK);
         S_AXI_AWADDR <= a;
         S_AXI_WDATA <= {24'h0, d};
         S_AXI_AWVALID <= 1'b1;
         S_AXI_WVALID <= 1'b1;
         S_AXI_BREADY <= 1'b1;
         #1;
         while (S_AXI_AWVALID || S_AXI_WVALID || S_AXI_BREADY) begin
            @(posedge CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID) begin
               S_AXI_BREADY <= 1'b0;
               rsp = S_AXI_BRESP;
            end
            #1;
         end
      end
   endtask

   task axi_rd(input [3:0] a);
      begin
         @(posedge CLK);
         S_AXI_ARADDR <= a;
         S_AXI_ARVALID <= 1'b1;
         S_AXI_RREADY <= 1'b1;
         #1;
         while (S_AXI_ARVALID || S_AXI_RREADY) begin
            @(posedge CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID) begin
               S_AXI_RREADY <= 1'b0;
               rd = S_AXI_RDATA;
               rsp = S_AXI_RRESP;
            end
            #1;
         end
      end
   endtask

   task rd_chk(input [3:0] a, input [31:0] exp);
      begin
         axi_rd(a);
         check("rdata", exp, rd);
         check("rresp", 2'h0, rsp);
      end
   endtask

   task settle;
      begin
         repeat (6) @(posedge CLK);
         #1;
      end
   endtask

   // Polls the complete flag; bounded so a dead port cannot hang here
   task wait_done;
      begin
         i = 0;
         rd = 32'h0;
         while (rd[7] !== 1'b1 && i < 100) begin
            axi_rd(4'h0);
            i = i + 1;
         end
      end
   endtask

   task finish_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   initial begin
      repeat (6) @(posedge CLK);
      RST <= 1'b0;
      rd_chk(4'h0, 32'h04);
      rd_chk(4'h4, 32'h07);
      rd_chk(4'h8, 32'h00);
      check("routed", 1'b1, NSS_ROUTED);
      axi_rd(4'h6);
      check("rresp", 2'h2, rsp);
      check("rdata", 32'h0, rd);
      axi_wr(4'h2, 8'h00);
      check("bresp", 2'h2, rsp);
      $display("test reset done");

      axi_wr(4'h8, 8'h03);
      check("bresp", 2'h0, rsp);
      axi_wr(4'h0, 8'h43);
      check("routed", 1'b0, NSS_ROUTED);
      check("sck_oe", 1'b1, SCK_OE);
      axi_wr(4'hc, 8'ha5);
      axi_wr(4'hc, 8'h3c);
      axi_wr(4'hc, 8'h77);
      axi_rd(4'h4);
      check("write_collision_flag", 1'b1, rd[6]);
      wait_done;
      rd_chk(4'hc, 32'h96);
      axi_wr(4'h0, 8'h43);
      axi_wr(4'h4, 8'h00);
      settle;
      check("irq", 1'b0, IRQ);
      wait_done;
      check("irq", 1'b1, IRQ);
      rd_chk(4'hc, 32'h5a);
      repeat (100) @(posedge CLK);
      check("far_rx", 16'ha53c, far_rx);
      check("far_bits", 32'h10, far_bits);
      $display("test master transfer done");

      axi_wr(4'h0, 8'h4d);
      settle;
      check("nss_oe", 1'b1, NSS_OE);
      check("nss_o", 1'b1, NSS_O);
      axi_wr(4'h0, 8'h49);
      settle;
      check("nss_o", 1'b0, NSS_O);
      $display("test select output done");

      axi_wr(4'h0, 8'h00);
      axi_wr(4'h0, 8'h47);
      settle;
      @(posedge CLK) NSS_I <= 1'b0;
      settle;
      check("sck_oe", 1'b0, SCK_OE);
      rd_chk(4'h0, 32'h26);
      check("irq", 1'b1, IRQ);
      @(posedge CLK) NSS_I <= 1'b1;
      settle;
      rd_chk(4'h0, 32'h26);
      $display("test mode fault done");

      for (j = 0; j < 4; j = j + 1) begin
         @(posedge CLK) NSS_I <= SL_NSS[3-j];
         axi_wr(4'h0, SL_CTRL[31-8*j -: 8]);
         settle;
         check("miso_oe", SL_OE[3-j], MISO_OE);
      end
      axi_wr(4'h0, 8'h01);
      axi_wr(4'hc, 8'h80);
      settle;
      check("miso_o", 1'b1, MISO_O);
      check("miso_oe", 1'b1, MISO_OE);
      $display("test slave drive done");
      finish_test;
   end
endmodule // test_spims_top

/* hw/spims_consts.vh */
// Purpose: Shared offsets, field positions, reset values and timing counts
// Assumes: AXI4-Lite register word per offset, data in bits 7:0
// Notes:   Included by the serial port top module only
`ifndef SPIMS_CONSTS_VH
`define SPIMS_CONSTS_VH

// Register byte offsets
`define SPIMS_OFF_CTRL      4'h0
`define SPIMS_OFF_CFG       4'h4
`define SPIMS_OFF_DIV       4'h8
`define SPIMS_OFF_DATA      4'hc

// Control register fields
`define SPIMS_CTRL_DONE     7
`define SPIMS_CTRL_MASTER_ENABLE_BIT    6
`define SPIMS_CTRL_MODE_FAULT_FLAG     5
`define SPIMS_CTRL_OVR      4
`define SPIMS_CTRL_SELHI    3
`define SPIMS_CTRL_SELLO    2
`define SPIMS_CTRL_IE       1
`define SPIMS_CTRL_EN       0

// Configuration / status register fields
`define SPIMS_CFG_BUSY      7
`define SPIMS_CFG_WRITE_COLLISION_FLAG      6
`define SPIMS_CFG_PHA       5
`define SPIMS_CFG_POL       4
`define SPIMS_CFG_SEL       3
`define SPIMS_CFG_NSSIN     2
`define SPIMS_CFG_SRMT      1
`define SPIMS_CFG_RXBMT     0

// Select pin modes
`define SPIMS_SEL_3WIRE     2'h0
`define SPIMS_SEL_4WIRE_IN  2'h1

// Reset values
`define SPIMS_CTRL_RST_MODE 2'h1
`define SPIMS_DIV_RST       8'h00

// Bus responses
`define SPIMS_RESP_OKAY     2'h0
`define SPIMS_RESP_SLVERR   2'h2

// Serial timing: 16 clock edges per byte
`define SPIMS_LAST_EDGE     4'hf
`define SPIMS_CLK_KHZ       10000
`define SPIMS_SCK_MAX_KHZ   12500
// Least half period of the serial clock, rounded up, never below one cycle
`define SPIMS_MIN_HALF_RAW  ((`SPIMS_CLK_KHZ + 2*`SPIMS_SCK_MAX_KHZ - 1) / (2*`SPIMS_SCK_MAX_KHZ))
`define SPIMS_MIN_HALF      ((`SPIMS_MIN_HALF_RAW < 1) ? 1 : `SPIMS_MIN_HALF_RAW)

`endif

/* hw/spims_div.v */
// Purpose: Half-period tick generator for the master serial clock
// Assumes: Tick period is div + min_half cycles
// Notes:   Counter restarts whenever disabled, so a byte starts aligned
`timescale 1ns/1ps
module spims_div #(
   parameter [8:0] MIN_HALF = 9'd1
) (
   input  wire       clk,
   input  wire       rst,
   input  wire       en,
   input  wire [7:0] div,
   output reg        tick
);
   reg  [8:0] cnt_r;
   wire [8:0] top = {1'b0, div} + MIN_HALF - 9'd1;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 9'd0;
         tick  <= 1'b0;
      end else if (!en) begin
         cnt_r <= 9'd0;
         tick  <= 1'b0;
      end else if (cnt_r >= top) begin
         cnt_r <= 9'd0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 9'd1;
         tick  <= 1'b0;
      end
   end
endmodule // spims_div

/* hw/spims_sync.v */
// Purpose: Two-flop synchroniser for pins entering the system clock domain
// Assumes: Inputs are quasi-static relative to CLK
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module spims_sync #(
   parameter WIDTH = 4
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta_r;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= {WIDTH{1'b0}};
         q      <= {WIDTH{1'b0}};
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // spims_sync

/* hw/spims_top.v */
// Purpose: Serial peripheral port, master or slave, with select-pin modes
// Assumes: AXI4-Lite register access; pins pass a two-flop synchroniser
// Notes:   Register data occupies bits 7:0 of each word
`timescale 1ns/1ps
`include "spims_consts.vh"

module spims_top (
   input  wire        CLK,
   input  wire        RST,
   input  wire [3:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [3:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   input  wire        SCK_I,
   output reg         SCK_O,
   output reg         SCK_OE,
   input  wire        MOSI_I,
   output reg         MOSI_O,
   output reg         MOSI_OE,
   input  wire        MISO_I,
   output reg         MISO_O,
   output reg         MISO_OE,
   input  wire        NSS_I,
   output reg         NSS_O,
   output reg         NSS_OE,
   output reg         NSS_ROUTED,
   output reg         IRQ
);
   function is_mapped;
      input [3:0] a;
      begin
         is_mapped = (a == `SPIMS_OFF_CTRL) || (a == `SPIMS_OFF_CFG) ||
                     (a == `SPIMS_OFF_DIV)  || (a == `SPIMS_OFF_DATA);
      end
   endfunction

   // Bus slave state
   reg  [3:0]  awaddr_r;
   reg         aw_got_r;
   reg  [7:0]  wdata_r;
   reg         wstrb0_r;
   reg         w_got_r;

   // Port state
   reg         en_r;
   reg         master_enable_bit_r;
   reg  [1:0]  mode_r;
   reg         ie_r;
   reg         done_r;
   reg         mode_fault_flag_r;
   reg         ovr_r;
   reg         write_collision_flag_r;
   reg         pha_r;
   reg         pol_r;
   reg  [7:0]  div_r;
   reg  [7:0]  txbuf_r;
   reg         txfull_r;
   reg  [7:0]  sh_r;
   reg         shfull_r;
   reg  [7:0]  rxsh_r;
   reg  [7:0]  rxbuf_r;
   reg         rxfull_r;
   reg         busy_r;
   reg  [3:0]  edge_r;
   reg         sckph_r;
   reg         sck_d_r;
   reg         nss_d_r;
   reg  [31:0] rdata_nxt;

   wire [3:0]  pins_s;
   wire        tick;
   wire        sck_s  = pins_s[3];
   wire        mosi_s = pins_s[2];
   wire        miso_s = pins_s[1];
   wire        nss_s  = ~pins_s[0];                                 // Reset reads as idle high

   spims_sync #(.WIDTH(4)) u_sync (
      .clk (CLK),
      .rst (RST),
      .d   ({SCK_I, MOSI_I, MISO_I, ~NSS_I}),
      .q   (pins_s)
   );

   wire master   = en_r & master_enable_bit_r;
   wire slave    = en_r & ~master_enable_bit_r;
   wire mode_3w  = (mode_r == `SPIMS_SEL_3WIRE);
   wire mode_in  = (mode_r == `SPIMS_SEL_4WIRE_IN);
   wire selected = mode_3w | (mode_in & ~nss_s);
   wire nss_fall = nss_d_r & ~nss_s;

   localparam [31:0] MIN_HALF_W = `SPIMS_MIN_HALF;
   // Divider only runs in master mode, so slave ignores its setting
   spims_div #(.MIN_HALF(MIN_HALF_W[8:0])) u_div (
      .clk  (CLK),
      .rst  (RST),
      .en   (master & busy_r),
      .div  (div_r),
      .tick (tick)
   );

   wire m_edge   = master & busy_r & tick;
   wire s_edge   = slave & selected & (sck_s ^ sck_d_r);
   wire any_edge = m_edge | s_edge;
   wire sample   = any_edge & (edge_r[0] == pha_r);
   wire change   = any_edge & (edge_r[0] != pha_r) &
                   (edge_r != 4'h0) & (edge_r != `SPIMS_LAST_EDGE);
   wire last     = any_edge & (edge_r == `SPIMS_LAST_EDGE);
   wire in_bit   = master ? miso_s : mosi_s;
   wire fault    = master & mode_in & nss_fall;

   // Bus handshakes
   wire aw_hs    = S_AXI_AWVALID & S_AXI_AWREADY;
   wire w_hs     = S_AXI_WVALID & S_AXI_WREADY;
   wire ar_hs    = S_AXI_ARVALID & S_AXI_ARREADY;
   wire wr_go    = aw_got_r & w_got_r & ~S_AXI_BVALID;
   wire wr_ok    = wr_go & wstrb0_r;
   wire wr_ctrl  = wr_ok & (awaddr_r == `SPIMS_OFF_CTRL);
   wire wr_cfg   = wr_ok & (awaddr_r == `SPIMS_OFF_CFG);
   wire wr_div   = wr_ok & (awaddr_r == `SPIMS_OFF_DIV);
   wire wr_data  = wr_ok & (awaddr_r == `SPIMS_OFF_DATA);
   wire rd_data  = ar_hs & (S_AXI_ARADDR == `SPIMS_OFF_DATA);

   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (S_AXI_ARADDR)
         `SPIMS_OFF_CTRL: rdata_nxt[7:0] = {done_r, master_enable_bit_r, mode_fault_flag_r, ovr_r,
                                            mode_r, ie_r, en_r};
         `SPIMS_OFF_CFG:  rdata_nxt[7:0] = {busy_r, write_collision_flag_r, pha_r, pol_r,
                                            selected & slave, nss_s,
                                            ~shfull_r, ~rxfull_r};
         `SPIMS_OFF_DIV:  rdata_nxt[7:0] = div_r;
         `SPIMS_OFF_DATA: rdata_nxt[7:0] = rxbuf_r;
         default:         rdata_nxt = 32'h0000_0000;
      endcase
   end

   // AXI4-Lite channels; address and data accepted in either order
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= `SPIMS_RESP_OKAY;
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RRESP   <= `SPIMS_RESP_OKAY;
         S_AXI_RDATA   <= 32'h0000_0000;
         awaddr_r      <= 4'h0;
         aw_got_r      <= 1'b0;
         wdata_r       <= 8'h00;
         wstrb0_r      <= 1'b0;
         w_got_r       <= 1'b0;
      end else begin
         S_AXI_AWREADY <= ~aw_got_r & ~aw_hs & ~S_AXI_BVALID;
         S_AXI_WREADY  <= ~w_got_r & ~w_hs & ~S_AXI_BVALID;
         if (aw_hs) begin
            awaddr_r <= S_AXI_AWADDR;
            aw_got_r <= 1'b1;
         end
         if (w_hs) begin
            wdata_r  <= S_AXI_WDATA[7:0];
            wstrb0_r <= S_AXI_WSTRB[0];
            w_got_r  <= 1'b1;
         end
         if (wr_go) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= is_mapped(awaddr_r) ? `SPIMS_RESP_OKAY : `SPIMS_RESP_SLVERR;
         end else if (S_AXI_BVALID & S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
         S_AXI_ARREADY <= ~S_AXI_RVALID & ~ar_hs;
         if (ar_hs) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rdata_nxt;
            S_AXI_RRESP  <= is_mapped(S_AXI_ARADDR) ? `SPIMS_RESP_OKAY : `SPIMS_RESP_SLVERR;
         end else if (S_AXI_RVALID & S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // Port engine; hardware sets come last so they beat a same-cycle clear
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         en_r     <= 1'b0;
         master_enable_bit_r  <= 1'b0;
         mode_r   <= `SPIMS_CTRL_RST_MODE;
         ie_r     <= 1'b0;
         done_r   <= 1'b0;
         mode_fault_flag_r   <= 1'b0;
         ovr_r    <= 1'b0;
         write_collision_flag_r   <= 1'b0;
         pha_r    <= 1'b0;
         pol_r    <= 1'b0;
         div_r    <= `SPIMS_DIV_RST;
         txbuf_r  <= 8'h00;
         txfull_r <= 1'b0;
         sh_r     <= 8'h00;
         shfull_r <= 1'b0;
         rxsh_r   <= 8'h00;
         rxbuf_r  <= 8'h00;
         rxfull_r <= 1'b0;
         busy_r   <= 1'b0;
         edge_r   <= 4'h0;
         sckph_r  <= 1'b0;
         sck_d_r  <= 1'b0;
         nss_d_r  <= 1'b1;
      end else begin
         sck_d_r <= sck_s;
         nss_d_r <= nss_s;
         // Flags clear by writing 0, writing 1 leaves them alone
         if (wr_ctrl) begin
            en_r    <= wdata_r[`SPIMS_CTRL_EN];
            master_enable_bit_r <= wdata_r[`SPIMS_CTRL_MASTER_ENABLE_BIT];
            mode_r  <= wdata_r[`SPIMS_CTRL_SELHI:`SPIMS_CTRL_SELLO];
            ie_r    <= wdata_r[`SPIMS_CTRL_IE];
            done_r  <= done_r & wdata_r[`SPIMS_CTRL_DONE];
            mode_fault_flag_r  <= mode_fault_flag_r & wdata_r[`SPIMS_CTRL_MODE_FAULT_FLAG];
            ovr_r   <= ovr_r & wdata_r[`SPIMS_CTRL_OVR];
         end
         if (wr_cfg) begin
            pha_r  <= wdata_r[`SPIMS_CFG_PHA];
            pol_r  <= wdata_r[`SPIMS_CFG_POL];
            write_collision_flag_r <= write_collision_flag_r & wdata_r[`SPIMS_CFG_WRITE_COLLISION_FLAG];
         end
         if (wr_div)
            div_r <= wdata_r;
         if (rd_data)
            rxfull_r <= 1'b0;
         if (wr_data) begin
            if (txfull_r)
               write_collision_flag_r <= 1'b1;
            else begin
               txbuf_r  <= wdata_r;
               txfull_r <= 1'b1;
            end
         end
         // Move buffer into an idle, empty shift register
         if (en_r & txfull_r & ~shfull_r & ~busy_r) begin
            sh_r     <= txbuf_r;
            shfull_r <= 1'b1;
            txfull_r <= 1'b0;
            if (master) begin
               busy_r  <= 1'b1;
               edge_r  <= 4'h0;
               sckph_r <= 1'b0;
            end
         end
         if (any_edge) begin
            busy_r  <= 1'b1;
            edge_r  <= edge_r + 4'h1;
            sckph_r <= ~sckph_r;
         end
         if (sample)
            rxsh_r <= {rxsh_r[6:0], in_bit};
         if (change)
            sh_r <= {sh_r[6:0], 1'b0};
         if (last) begin
            busy_r   <= 1'b0;
            shfull_r <= 1'b0;
            edge_r   <= 4'h0;
            sckph_r  <= 1'b0;
            done_r   <= 1'b1;
            if (slave & rxfull_r)
               ovr_r <= 1'b1;
            else begin
               rxbuf_r  <= sample ? {rxsh_r[6:0], in_bit} : rxsh_r;
               rxfull_r <= 1'b1;
            end
         end
         // Select falling edge restarts a slave byte
         if (~en_r | (slave & mode_in & nss_fall)) begin
            busy_r  <= 1'b0;
            edge_r  <= 4'h0;
            sckph_r <= 1'b0;
         end
         // Another master took the bus: stay off until software re-enables
         if (fault) begin
            master_enable_bit_r  <= 1'b0;
            en_r     <= 1'b0;
            mode_fault_flag_r   <= 1'b1;
            busy_r   <= 1'b0;
            edge_r   <= 4'h0;
            sckph_r  <= 1'b0;
            shfull_r <= 1'b0;
         end
      end
   end

   // Pin drivers, one cycle behind the engine state
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         SCK_O      <= 1'b0;
         SCK_OE     <= 1'b0;
         MOSI_O     <= 1'b0;
         MOSI_OE    <= 1'b0;
         MISO_O     <= 1'b0;
         MISO_OE    <= 1'b0;
         NSS_O      <= 1'b0;
         NSS_OE     <= 1'b0;
         NSS_ROUTED <= 1'b0;
         IRQ        <= 1'b0;
      end else begin
         SCK_O      <= pol_r ^ sckph_r;
         SCK_OE     <= master;
         MOSI_O     <= sh_r[7];
         MOSI_OE    <= master;
         MISO_O     <= sh_r[7];
         MISO_OE    <= slave & selected;
         NSS_O      <= mode_r[0];
         NSS_OE     <= mode_r[1];
         NSS_ROUTED <= ~mode_3w;
         IRQ        <= ie_r & (done_r | write_collision_flag_r | mode_fault_flag_r | ovr_r);
      end
   end
endmodule // spims_top
